// ### design/uss_cfg.svh
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

// character and queue sizes
`define USS_DATA_W 8
`define USS_RX_DEPTH 2
// oversampling ticks per bit and sampling points
`define USS_TICK_W 4
`define USS_TICK_LAST 4'hf
`define USS_SAMP_FIRST 4'h7
`define USS_SAMP_LAST 4'h9
// frame bit indices: 0 start, 1..8 data, 9 parity or stop, 10 stop after parity
`define USS_IDX_W 4
`define USS_IDX_START 4'h0
`define USS_IDX_DATA_LAST 4'h8
`define USS_IDX_PAR 4'h9
`define USS_IDX_STOP_NOPAR 4'h9
`define USS_IDX_STOP_PAR 4'ha
// status register layout and power-on value
`define USS_STAT_RESET 8'h0b
`define USS_BIT_PARITY_ERROR 7
`define USS_BIT_NF 6
`define USS_BIT_FRAMING_ERROR 5
`define USS_BIT_OVERRUN_ERROR 4
`define USS_BIT_RECEIVER_IDLE 3
`define USS_BIT_RX_DATA_READY 2
`define USS_BIT_TRANSMITTER_IDLE 1
`define USS_BIT_TX_BUFFER_EMPTY 0

`endif

// ### design/uss_pkg.sv
`default_nettype none

package uss_pkg;

    typedef struct packed {
        logic parity_error;
        logic noise_flag;
        logic framing_error;
        logic overrun_error;
        logic receiver_idle;
        logic rx_data_ready;
        logic transmitter_idle;
        logic tx_buffer_empty;
    } uss_status_t;

    typedef struct packed {
        logic module_enable;
        logic transmitter_on;
        logic receiver_on;
        logic parity_en;
        logic parity_odd;
        logic receive_irq_enable;
    } uss_ctrl_t;

    typedef enum logic [0:0] {
        RX_IDLE,
        RX_BITS
    } uss_rx_state_t;

    typedef enum logic [0:0] {
        TX_IDLE,
        TX_BITS
    } uss_tx_state_t;

endpackage

`default_nettype wire

// ### design/uss_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module uss_fifo #(
    parameter int W = 8,
    parameter int D = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(D+1)-1:0] count_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D+1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;

    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (cnt_q != CW'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign count_o = cnt_q;

    // entries are plain flops, written in place
    for (genvar e = 0; e < D; e++) begin : g_entry
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mem_q[e] <= '0;
            end else if (ce_i && push && !flush_i && wr_ptr_q == AW'(e)) begin
                mem_q[e] <= in_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            if (flush_i) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                cnt_q <= '0;
            end else begin
                if (push) begin
                    wr_ptr_q <= (wr_ptr_q == AW'(D-1)) ? '0 : wr_ptr_q + 1'b1;
                end
                if (pop) begin
                    rd_ptr_q <= (rd_ptr_q == AW'(D-1)) ? '0 : rd_ptr_q + 1'b1;
                end
                cnt_q <= cnt_q + CW'(push) - CW'(pop);
            end
        end
    end

endmodule

`default_nettype wire

// ### design/uss_uart.sv
// What this block does
// R1: one 8-bit shared data register
// R2: status read-only; idle flags reset to one
// R3: bit 7 flags parity failure when enabled
// R4: status read then data access clears errors
// R5: bit 6 noise flag, never on overrun
// R6: bit 5 flags wrongly framed character
// R7: bit 4 overrun blocks further data transfers
// R8: bit 3 low from start to stop
// R9: bit 2 set on transfer; raises interrupt
// R10: errors flagged with receive-available flag
// R11: receive flag clears after sequence, queue empty
// R12: bit 1 set when empty, nothing shifting
// R13: status read then write clears transmitter idle
// R14: no idle while character is queued
// R15: bit 0 set on shift load, sequence clears
// R16: transmitter enable also sets transmit-empty
// R17: two-entry receive queue before data reads
// R18: writes load transmit, reads return receive
// R19: shift out and in LSB first
// R20: module disable clears errors, sets idle flags
`timescale 1ns/1ps
`default_nettype none
`include "uss_cfg.svh"

module uss_uart
    import uss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire uss_ctrl_t ctrl_i,
    input wire logic bit_tick_i,
    input wire logic status_rd_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [`USS_DATA_W-1:0] data_wdata_i,
    output uss_status_t status_o,
    output logic [`USS_DATA_W-1:0] data_rdata_o,
    output logic rx_irq_o,
    input wire logic rx_i,
    output logic tx_o,
    output logic tx_oe_o
);
    localparam int DW = `USS_DATA_W;
    localparam int CW = $clog2(`USS_RX_DEPTH + 1);

    // status flags
    logic parity_error_q;
    logic nf_q;
    logic framing_error_q;
    logic overrun_error_q;
    logic rx_data_ready_q;
    logic transmitter_idle_q;
    logic tx_buffer_empty_q;
    logic rx_arm_q;
    logic tx_arm_q;
    logic transmitter_on_q;

    // receiver
    logic [1:0] rx_sync_q;
    uss_rx_state_t rx_st_q;
    logic [`USS_TICK_W-1:0] rx_tick_q;
    logic [`USS_IDX_W-1:0] rx_idx_q;
    logic [2:0] rx_vote_q;
    logic [DW-1:0] rx_sh_q;
    logic rx_pbit_q;
    logic rx_noise_q;
    logic [DW-1:0] rd_data_q;

    // transmitter
    uss_tx_state_t tx_st_q;
    logic [DW-1:0] tx_buf_q;
    logic tx_full_q;
    logic [DW+2:0] tx_sh_q;
    logic [`USS_TICK_W-1:0] tx_tick_q;
    logic [`USS_IDX_W-1:0] tx_idx_q;

    // fifo side
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DW-1:0] fifo_out_data;
    logic [CW-1:0] fifo_cnt;

    wire en = ctrl_i.module_enable;
    wire rx_run = en && ctrl_i.receiver_on;
    wire tx_run = en && ctrl_i.transmitter_on;
    wire rx_s = rx_sync_q[1];

    // receive sampling and frame bookkeeping
    wire rx_samp = bit_tick_i && (rx_tick_q >= `USS_SAMP_FIRST) && (rx_tick_q <= `USS_SAMP_LAST);
    wire rx_bit_end = bit_tick_i && (rx_tick_q == `USS_TICK_LAST) && (rx_st_q == RX_BITS);
    wire rx_maj = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[0] & rx_vote_q[2])
        | (rx_vote_q[1] & rx_vote_q[2]);
    wire rx_noisy = !(&rx_vote_q) && (|rx_vote_q);
    wire [`USS_IDX_W-1:0] rx_stop_idx = ctrl_i.parity_en ? `USS_IDX_STOP_PAR
        : `USS_IDX_STOP_NOPAR;
    wire rx_start_seen = rx_run && (rx_st_q == RX_IDLE) && !rx_s;
    wire rx_false_start = rx_bit_end && (rx_idx_q == `USS_IDX_START) && rx_maj;
    // a frame ending as the receiver is switched off is dropped with the flush
    wire rx_done = rx_run && rx_bit_end && (rx_idx_q == rx_stop_idx);
    wire rx_is_data = (rx_idx_q != `USS_IDX_START) && (rx_idx_q <= `USS_IDX_DATA_LAST);
    wire rx_is_par = ctrl_i.parity_en && (rx_idx_q == `USS_IDX_PAR);
    // the word being checked is complete once the stop bit ends
    wire rx_parity_error = ctrl_i.parity_en && ((^rx_sh_q) ^ rx_pbit_q ^ ctrl_i.parity_odd);
    wire rx_framing_error = !rx_maj;
    wire rx_word_noise = rx_noise_q || rx_noisy;

    // a full queue or a pending overrun drops the new character
    wire rx_push = rx_done && fifo_in_ready && !overrun_error_q;
    wire rx_overrun = rx_done && !rx_push;

    // software access decode
    wire data_pop = data_rd_i && fifo_out_valid;
    wire rx_clear = data_rd_i && rx_arm_q;
    wire tx_clear = data_wr_i && tx_arm_q;
    wire rx_any = rx_data_ready_q || parity_error_q || nf_q || framing_error_q || overrun_error_q;
    wire rx_last = (fifo_cnt <= CW'(1));
    wire transmitter_on_rise = tx_run && !transmitter_on_q;

    // transmit frame
    wire tx_load = tx_run && tx_full_q && (tx_st_q == TX_IDLE);
    wire tx_par = (^tx_buf_q) ^ ctrl_i.parity_odd;
    wire [`USS_IDX_W-1:0] tx_last_idx = ctrl_i.parity_en ? `USS_IDX_STOP_PAR
        : `USS_IDX_STOP_NOPAR;
    wire tx_bit_end = bit_tick_i && (tx_tick_q == `USS_TICK_LAST) && (tx_st_q == TX_BITS);
    wire tx_done = tx_bit_end && (tx_idx_q == tx_last_idx);
    wire [DW+2:0] tx_frame = ctrl_i.parity_en ? {1'b1, tx_par, tx_buf_q, 1'b0}
        : {2'b11, tx_buf_q, 1'b0};
    // idle needs an empty buffer and a quiet shifter
    // a write in this cycle already queues a character
    wire transmitter_idle_set = tx_buffer_empty_q && (tx_st_q == TX_IDLE) && !tx_full_q && !data_wr_i;

    // R17: two-entry receive queue
    uss_fifo #(
        .W(DW),
        .D(`USS_RX_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .flush_i(!rx_run),
        .in_valid_i(rx_push),
        .in_data_i(rx_sh_q),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(data_rd_i),
        .count_o(fifo_cnt)
    );

    // two flops before the pin is looked at
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_sync_q <= 2'h3;
        end else if (ce_i) begin
            rx_sync_q <= {rx_sync_q[0], rx_i};
        end
    end

    // R8: start detect to stop end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_st_q <= RX_IDLE;
            rx_tick_q <= '0;
            rx_idx_q <= '0;
        end else if (ce_i) begin
            if (!rx_run || rx_false_start || rx_done) begin
                rx_st_q <= RX_IDLE;
            end else if (rx_start_seen) begin
                rx_st_q <= RX_BITS;
                rx_tick_q <= '0;
                rx_idx_q <= '0;
            end else if (rx_st_q == RX_BITS && bit_tick_i) begin
                rx_tick_q <= rx_tick_q + 1'b1;
                if (rx_bit_end) begin
                    rx_idx_q <= rx_idx_q + 1'b1;
                end
            end
        end
    end

    // R19: data enters at the top, LSB first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_vote_q <= 3'h7;
            rx_sh_q <= '0;
            rx_pbit_q <= 1'b0;
            rx_noise_q <= 1'b0;
        end else if (ce_i) begin
            if (rx_start_seen) begin
                rx_noise_q <= 1'b0;
            end else if (rx_bit_end) begin
                rx_noise_q <= rx_word_noise;
            end
            if (rx_samp) begin
                rx_vote_q <= {rx_vote_q[1:0], rx_s};
            end
            if (rx_bit_end && rx_is_data) begin
                rx_sh_q <= {rx_maj, rx_sh_q[DW-1:1]};
            end
            if (rx_bit_end && rx_is_par) begin
                rx_pbit_q <= rx_maj;
            end
        end
    end

    // R1: read data held in a register
    // R18: reads return the receive side
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_q <= '0;
        end else if (ce_i && data_pop) begin
            rd_data_q <= fifo_out_data;
        end
    end

    // the status read arms the clearing access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_arm_q <= 1'b0;
            tx_arm_q <= 1'b0;
        end else if (ce_i) begin
            if (status_rd_i && rx_any) begin
                rx_arm_q <= 1'b1;
            end else if (data_rd_i) begin
                rx_arm_q <= 1'b0;
            end
            if (status_rd_i && (tx_buffer_empty_q || transmitter_idle_q)) begin
                tx_arm_q <= 1'b1;
            end else if (data_wr_i) begin
                tx_arm_q <= 1'b0;
            end
        end
    end

    // receive flags; a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parity_error_q <= 1'b0;
            nf_q <= 1'b0;
            framing_error_q <= 1'b0;
            overrun_error_q <= 1'b0;
            rx_data_ready_q <= 1'b0;
        end else if (ce_i) begin
            // R20: disable drops the receive flags
            if (!en) begin
                parity_error_q <= 1'b0;
                nf_q <= 1'b0;
                framing_error_q <= 1'b0;
                overrun_error_q <= 1'b0;
                rx_data_ready_q <= 1'b0;
            end else begin
                // R3: parity error on push
                // R10: errors set with the available flag
                if (rx_push && rx_parity_error) begin
                    parity_error_q <= 1'b1;
                end else if (rx_clear) begin
                    parity_error_q <= 1'b0;
                end
                // R5: overrun characters never flag noise
                if (rx_push && rx_word_noise) begin
                    nf_q <= 1'b1;
                end else if (rx_clear) begin
                    nf_q <= 1'b0;
                end
                // R6: stop bit sampled low
                if (rx_push && rx_framing_error) begin
                    framing_error_q <= 1'b1;
                end else if (rx_clear) begin
                    framing_error_q <= 1'b0;
                end
                // R7: overrun flag set on drop
                // R4: errors cleared by the sequence
                if (rx_overrun) begin
                    overrun_error_q <= 1'b1;
                end else if (rx_clear) begin
                    overrun_error_q <= 1'b0;
                end
                // R9: transfer into the data register
                // R11: clears only when the queue drains
                if (rx_push) begin
                    rx_data_ready_q <= 1'b1;
                end else if (rx_clear && rx_last) begin
                    rx_data_ready_q <= 1'b0;
                end
            end
        end
    end

    // R18: writes load the transmit buffer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buf_q <= '0;
            tx_full_q <= 1'b0;
        end else if (ce_i) begin
            if (data_wr_i) begin
                tx_buf_q <= data_wdata_i;
            end
            if (!tx_run) begin
                tx_full_q <= 1'b0;
            end else if (data_wr_i) begin
                tx_full_q <= 1'b1;
            end else if (tx_load) begin
                tx_full_q <= 1'b0;
            end
        end
    end

    // R19: frame leaves bit 0 first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= '1;
            tx_tick_q <= '0;
            tx_idx_q <= '0;
        end else if (ce_i) begin
            if (!tx_run || tx_done) begin
                tx_st_q <= TX_IDLE;
                tx_sh_q <= '1;
            end else if (tx_load) begin
                tx_st_q <= TX_BITS;
                tx_sh_q <= tx_frame;
                tx_tick_q <= '0;
                tx_idx_q <= '0;
            end else if (tx_st_q == TX_BITS && bit_tick_i) begin
                tx_tick_q <= tx_tick_q + 1'b1;
                if (tx_bit_end) begin
                    tx_sh_q <= {1'b1, tx_sh_q[DW+2:1]};
                    tx_idx_q <= tx_idx_q + 1'b1;
                end
            end
        end
    end

    // transmit flags; a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buffer_empty_q <= 1'b1;
            transmitter_idle_q <= 1'b1;
            transmitter_on_q <= 1'b0;
        end else if (ce_i) begin
            transmitter_on_q <= tx_run;
            // R20: disable forces the idle flags
            if (!en) begin
                tx_buffer_empty_q <= 1'b1;
                transmitter_idle_q <= 1'b1;
            end else begin
                // R15: loaded into the shifter
                // R16: enabling reports an empty buffer
                if (tx_load || transmitter_on_rise) begin
                    tx_buffer_empty_q <= 1'b1;
                end else if (tx_clear) begin
                    tx_buffer_empty_q <= 1'b0;
                end
                // R12: empty and nothing shifting
                // R14: a queued character blocks idle
                // R13: cleared by the write sequence
                if (transmitter_idle_set) begin
                    transmitter_idle_q <= 1'b1;
                end else if (tx_clear) begin
                    transmitter_idle_q <= 1'b0;
                end
            end
        end
    end

    // R2: all status bits are read-only
    assign status_o = '{
        parity_error: parity_error_q,
        noise_flag: nf_q,
        framing_error: framing_error_q,
        overrun_error: overrun_error_q,
        receiver_idle: (rx_st_q == RX_IDLE),
        rx_data_ready: rx_data_ready_q,
        transmitter_idle: transmitter_idle_q,
        tx_buffer_empty: tx_buffer_empty_q
    };
    assign data_rdata_o = rd_data_q;
    // R9: receive interrupt gated by its enable
    assign rx_irq_o = rx_data_ready_q && ctrl_i.receive_irq_enable;
    // R12: line rests high when not shifting
    assign tx_o = tx_sh_q[0];
    assign tx_oe_o = tx_run;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_RECEIVER_IDLE_START: assert property ( // R8
        ce_i && rx_start_seen |=> !status_o.receiver_idle
    ) else $error("receiver idle did not drop at start bit");

    AST_RX_DATA_READY_PUSH: assert property ( // R9
        ce_i && rx_push |=> status_o.rx_data_ready && fifo_out_valid
    ) else $error("receive flag not set on transfer");

    AST_IRQ_GATE: assert property ( // R9
        ce_i && rx_push |=> rx_irq_o == ctrl_i.receive_irq_enable
    ) else $error("receive interrupt does not follow flag and enable");

    AST_ERR_WITH_RX_DATA_READY: assert property ( // R10
        ce_i && en && rx_push && rx_framing_error |=> status_o.framing_error && status_o.rx_data_ready
    ) else $error("framing error not flagged with receive flag");

    AST_OVERRUN_ERROR_BLOCKS: assert property ( // R7
        ce_i && overrun_error_q |=> fifo_cnt <= $past(fifo_cnt)
    ) else $error("transfer while overrun set");

    AST_NF_NOT_OVERRUN: assert property ( // R5
        ce_i && rx_overrun && !nf_q |=> !nf_q
    ) else $error("noise flagged for an overrun character");

    AST_PARITY_ERROR_ONLY_PAR: assert property ( // R3
        ce_i && !ctrl_i.parity_en && !parity_error_q |=> !parity_error_q
    ) else $error("parity error without parity checking");

    AST_TX_BUFFER_EMPTY_LOAD: assert property ( // R15
        ce_i && en && tx_load |=> status_o.tx_buffer_empty ##0 tx_st_q == TX_BITS
    ) else $error("transmit-empty not set on shifter load");

    AST_TRANSMITTER_IDLE_QUEUED: assert property ( // R14
        ce_i && tx_full_q && !transmitter_idle_q && en |=> !transmitter_idle_q
    ) else $error("transmitter idle raised with a queued character");

    AST_DISABLE: assert property ( // R20
        ce_i && !en |=> status_o == `USS_STAT_RESET
    ) else $error("disable did not restore status flags");

    AST_TX_REST_HIGH: assert property ( // R12
        tx_st_q == TX_IDLE |-> tx_o
    ) else $error("transmit line not high while idle");

    COV_RX_PUSH: cover property (ce_i && rx_push);
    COV_OVERRUN: cover property (ce_i && rx_overrun);
    COV_RX_CLEAR: cover property (ce_i && rx_clear && rx_last && rx_data_ready_q);
    COV_TX_DONE: cover property (ce_i && tx_done);

endmodule

`default_nettype wire

// ### verif/uss_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none

module uss_serial_peer #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk_i,
    input wire logic tx_i,
    output logic rx_o
);
    initial rx_o = 1'b1;

    // fault: 0 clean, 1 bad parity, 2 bad stop, 3 glitch in bit 3
    task automatic send(input logic [7:0] d, input logic par_en, input logic par_odd,
                        input int fault);
        logic [10:0] bits;
        logic stop;
        int n;
        stop = (fault != 2);
        // lsb first after the start bit
        if (par_en) begin
            bits = {stop, ^d ^ par_odd ^ (fault == 1), d, 1'b0};
            n = 11;
        end else begin
            bits = {1'b1, stop, d, 1'b0};
            n = 10;
        end
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < BIT_CLKS; c++) begin
                @(posedge clk_i);
                #1;
                rx_o = bits[i] ^ (fault == 3 && i == 4 && c >= 18 && c <= 20);
            end
        end
        @(posedge clk_i);
        #1;
        rx_o = 1'b1;
    endtask

    // samples mid-bit; framed is low on a bad start or stop level
    task automatic recv(output logic [7:0] d, output logic framed);
        int guard;
        guard = 0;
        while (tx_i !== 1'b0 && guard < 4000) begin
            @(posedge clk_i);
            #1;
            guard++;
        end
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        #1;
        framed = (tx_i === 1'b0);
        // first data bit is the lsb
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            #1;
            d[i] = tx_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        #1;
        framed = framed && (tx_i === 1'b1);
    endtask
endmodule

`default_nettype wire

// ### verif/uss_uart_bench.sv
`timescale 1ns/1ps
`default_nettype none

module uss_uart_bench
    import uss_pkg::*;
;
    // ticks every other clock: 32 clocks per bit
    localparam int BIT_CLKS = 32;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic bit_tick_i = 1'b0;
    logic status_rd_i = 1'b0;
    logic data_rd_i = 1'b0;
    logic data_wr_i = 1'b0;
    logic [7:0] data_wdata_i = 8'h00;
    uss_ctrl_t ctrl = 6'h29;
    uss_status_t status_o;
    logic [7:0] data_rdata_o;
    logic rx_irq_o, rx_line, tx_o, tx_oe_o;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    uss_uart u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .ctrl_i(ctrl),
        .bit_tick_i(bit_tick_i), .status_rd_i(status_rd_i), .data_rd_i(data_rd_i),
        .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .status_o(status_o),
        .data_rdata_o(data_rdata_o), .rx_irq_o(rx_irq_o), .rx_i(rx_line),
        .tx_o(tx_o), .tx_oe_o(tx_oe_o)
    );

    uss_serial_peer #(.BIT_CLKS(BIT_CLKS)) u_peer (
        .clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_line)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        #1;
        bit_tick_i = ~bit_tick_i;
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            errors = errors + 1;
            results;
        end
    end

    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task cyc;
        @(posedge clk_i);
        #1;
    endtask

    // one-cycle software strobes; only raised ones are touched
    task sw(input logic s, input logic r, input logic w, input logic [7:0] d);
        if (s) status_rd_i = 1'b1;
        if (r) data_rd_i = 1'b1;
        if (w) data_wr_i = 1'b1;
        if (w) data_wdata_i = d;
        cyc;
        if (s) status_rd_i = 1'b0;
        if (r) data_rd_i = 1'b0;
        if (w) data_wr_i = 1'b0;
    endtask

    task wait_ready;
        int g;
        g = 0;
        while (status_o.rx_data_ready !== 1'b1 && g < 200) begin
            cyc;
            g++;
        end
    endtask

    task read_byte(input logic [7:0] exp);
        sw(1'b1, 1'b0, 1'b0, 8'h00);
        sw(1'b0, 1'b1, 1'b0, 8'h00);
        check("rdata", data_rdata_o, exp);
    endtask

    task t_reset;
        check("status", status_o, 8'h0b);
        check("tx_line", tx_o, 1'b1);
        check("irq", rx_irq_o, 1'b0);
        $display("test reset done");
    endtask

    task t_rx_basic;
        fork
            u_peer.send(8'ha5, 1'b0, 1'b0, 0);
            begin
                repeat (100) cyc;
                check("receiver_idle", status_o.receiver_idle, 1'b0);
            end
        join
        wait_ready;
        check("errors", status_o & 8'he0, 8'h00);
        check("irq", rx_irq_o, 1'b1);
        repeat (4) cyc;
        ctrl.receive_irq_enable = 1'b0;
        cyc;
        check("irq", rx_irq_o, 1'b0);
        ctrl.receive_irq_enable = 1'b1;
        check("receiver_idle", status_o.receiver_idle, 1'b1);
        read_byte(8'ha5);
        check("rx_data_ready", status_o.rx_data_ready, 1'b0);
        check("irq", rx_irq_o, 1'b0);
        $display("test rx_basic done");
    endtask

    task t_rx_errors;
        logic [7:0] exp;
        for (int k = 0; k <= 3; k++) begin
            ctrl.parity_en = (k <= 1);
            ctrl.parity_odd = (k == 1);
            exp = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : (k == 2) ? 8'h20 : 8'h40;
            u_peer.send(8'h5a, ctrl.parity_en, ctrl.parity_odd, k);
            wait_ready;
            check("error_bits", status_o & 8'he0, exp);
            sw(1'b1, 1'b0, 1'b0, 8'h00);
            sw(1'b0, 1'b1, 1'b0, 8'h00);
            check("cleared", status_o & 8'hf4, 8'h00);
        end
        ctrl.parity_en = 1'b0;
        ctrl.parity_odd = 1'b0;
        $display("test rx_errors done");
    endtask

    task t_overrun;
        u_peer.send(8'h11, 1'b0, 1'b0, 0);
        u_peer.send(8'h22, 1'b0, 1'b0, 0);
        // third frame noisy, lands on a full queue
        u_peer.send(8'h33, 1'b0, 1'b0, 3);
        repeat (20) cyc;
        check("overrun", status_o.overrun_error, 1'b1);
        check("noise", status_o.noise_flag, 1'b0);
        read_byte(8'h11);
        check("overrun", status_o.overrun_error, 1'b0);
        check("rx_data_ready", status_o.rx_data_ready, 1'b1);
        read_byte(8'h22);
        check("rx_data_ready", status_o.rx_data_ready, 1'b0);
        $display("test overrun done");
    endtask

    task t_tx;
        logic [7:0] got_a, got_b;
        logic ok_a, ok_b;
        int g;
        // empty the flag first so that enabling has to set it again
        sw(1'b1, 1'b0, 1'b0, 8'h00);
        sw(1'b0, 1'b0, 1'b1, 8'h00);
        check("tx_buffer_empty", status_o.tx_buffer_empty, 1'b0);
        ctrl.transmitter_on = 1'b1;
        cyc;
        check("tx_buffer_empty", status_o.tx_buffer_empty, 1'b1);
        check("tx_oe", tx_oe_o, 1'b1);
        fork
            begin
                u_peer.recv(got_a, ok_a);
                check("transmitter_idle", status_o.transmitter_idle, 1'b0);
                u_peer.recv(got_b, ok_b);
            end
            begin
                sw(1'b1, 1'b0, 1'b0, 8'h00);
                sw(1'b0, 1'b0, 1'b1, 8'hc3);
                check("tx_buffer_empty", status_o.tx_buffer_empty, 1'b0);
                check("transmitter_idle", status_o.transmitter_idle, 1'b0);
                cyc;
                check("tx_buffer_empty", status_o.tx_buffer_empty, 1'b1);
                sw(1'b1, 1'b0, 1'b0, 8'h00);
                sw(1'b0, 1'b0, 1'b1, 8'h96);
                check("tx_buffer_empty", status_o.tx_buffer_empty, 1'b0);
            end
        join
        check("tx_data", got_a, 8'hc3);
        check("tx_data", got_b, 8'h96);
        check("framed", {ok_a, ok_b}, 2'b11);
        g = 0;
        while (status_o.transmitter_idle !== 1'b1 && g < 64) begin
            cyc;
            g++;
        end
        check("transmitter_idle", status_o.transmitter_idle, 1'b1);
        check("tx_line", tx_o, 1'b1);
        $display("test tx done");
    endtask

    task t_disable;
        u_peer.send(8'h77, 1'b0, 1'b0, 2);
        wait_ready;
        ctrl.module_enable = 1'b0;
        cyc;
        cyc;
        check("status", status_o, 8'h0b);
        check("irq", rx_irq_o, 1'b0);
        check("tx_oe", tx_oe_o, 1'b0);
        ctrl.module_enable = 1'b1;
        $display("test disable done");
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        t_reset;
        t_rx_basic;
        t_rx_errors;
        t_overrun;
        t_tx;
        t_disable;
        results;
    end
endmodule

`default_nettype wire
